// [shared/pcd_regs.vh]
`ifndef PCD_REGS_VH
`define PCD_REGS_VH
// ==========================================================
// Timing figures and derived cycle counts at 100 MHz.
`define PCD_CLK_MHZ          100
`define PCD_SHDN_US          180
`define PCD_SHDN_CYC         (`PCD_SHDN_US * `PCD_CLK_MHZ)
`define PCD_SW_KHZ           600
`define PCD_SW_DIV           ((`PCD_CLK_MHZ * 1000) / `PCD_SW_KHZ)
`define PCD_STEP_MS          213
`define PCD_STEP_CYC         (`PCD_STEP_MS * `PCD_CLK_MHZ * 1000)
`define PCD_HALF_ILIM_MS     5
`define PCD_HALF_ILIM_CYC    (`PCD_HALF_ILIM_MS * `PCD_CLK_MHZ * 1000)
`define PCD_OPEN_CNT         8
`define PCD_LEVELS           32
// ==========================================================
// State codes.
`define PCD_ST_OFF           2'h0
`define PCD_ST_RUN           2'h1
`define PCD_ST_FAULT         2'h2
`endif

// [core/pcd_sync.v]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Two-stage synchroniser for asynchronous level inputs.
module pcd_sync #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         rst_n,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_r;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // pcd_sync
`default_nettype wire

// [core/pcd_ctrl.v]
`timescale 1ns/100ps
`default_nettype none
`include "pcd_regs.vh"
module pcd_ctrl #(
    parameter SHDN_CYC  = `PCD_SHDN_CYC,
    parameter STEP_CYC  = `PCD_STEP_CYC,
    parameter HALF_CYC  = `PCD_HALF_ILIM_CYC,
    parameter SW_DIV    = `PCD_SW_DIV
) (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       ctrl_pin,
    input  wire       switch_node_ovp,
    input  wire       feedback_sense_low,
    input  wire       uvlo_flag,
    input  wire       otp_flag,
    output reg        sw_gate_en,
    output reg        sw_clk_tick,
    output reg  [4:0] string_current_level,
    output reg  [5:0] ref_step,
    output reg        ilim_half,
    output reg        active
);
    // ==========================================================
    // State codes and sized limits.
    localparam [1:0]  ST_OFF    = `PCD_ST_OFF;
    localparam [1:0]  ST_RUN    = `PCD_ST_RUN;
    localparam [1:0]  ST_FAULT  = `PCD_ST_FAULT;
    localparam [31:0] SW_LAST   = SW_DIV - 1;
    localparam [31:0] SHDN_LAST = SHDN_CYC - 1;
    localparam [31:0] STEP_LAST = STEP_CYC - 1;
    localparam [31:0] OPEN_LAST = `PCD_OPEN_CNT - 1;
    localparam [31:0] LEVELS    = `PCD_LEVELS;

    // ==========================================================
    // Input synchronisation.
    // Every pin input passes two flip-flops before any logic reads it.
    wire [3:0] syn;

    pcd_sync #(.W(4)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      ({ctrl_pin, switch_node_ovp, feedback_sense_low, otp_flag}),
        .dout     (syn)
    );

    // Undervoltage is sampled too; it shares the same treatment.
    wire uv_s;

    pcd_sync #(.W(1)) u_sync_uv (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (uvlo_flag),
        .dout     (uv_s)
    );

    wire ctrl_s = syn[3];
    wire ovp_s  = syn[2];
    wire fbl_s  = syn[1];
    wire ot_s   = syn[0];

    // ==========================================================
    // Switching clock divider. It runs free from reset, so the phase of
    // the switching cycle does not follow the moment of enable.
    reg [7:0] div_r;
    wire      sw_tick = (div_r == SW_LAST[7:0]);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            div_r <= 8'h00;
        end else if (sw_tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // ==========================================================
    // Control pin: edge count and long-low shutdown timer.
    reg        ctrl_d_r;
    reg [31:0] low_cnt_r;
    reg [1:0]  st_r;
    reg [4:0]  edges_r;
    // The edge register resets low, the idle level of the pin, so no false
    // falling edge follows reset.
    wire       fall = ctrl_d_r & ~ctrl_s;
    // The low timer saturates, so a pin parked low never wraps back into run.
    wire       long_low = (low_cnt_r >= SHDN_LAST) & ~ctrl_s;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_d_r  <= 1'b0;
            low_cnt_r <= 32'h0;
        end else begin
            ctrl_d_r <= ctrl_s;
            if (ctrl_s) begin
                low_cnt_r <= 32'h0;
            end else if (!long_low) begin
                low_cnt_r <= low_cnt_r + 32'h1;
            end
        end
    end

    // ==========================================================
    // Open-string detector, evaluated once per switching cycle.
    reg [3:0] open_cnt_r;
    // A tick without both flags starts the count of eight over.
    wire      open_trip = (open_cnt_r == OPEN_LAST[3:0]) & ovp_s & fbl_s & sw_tick;

    always @(posedge core_clk) begin
        if (!rst_n || st_r != ST_RUN) begin
            open_cnt_r <= 4'h0;
        end else if (sw_tick) begin
            if (ovp_s & fbl_s) begin
                open_cnt_r <= open_cnt_r + 4'h1;
            end else begin
                open_cnt_r <= 4'h0;
            end
        end
    end

    // ==========================================================
    // Main state machine and soft-start timers.
    reg [31:0] step_cnt_r;
    reg [31:0] half_cnt_r;
    // Undervoltage and overtemperature release on their own; the
    // open-string latch does not.
    wire       hold_off = uv_s | ot_s;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            st_r       <= ST_OFF;
            edges_r    <= 5'h00;
            step_cnt_r <= 32'h0;
            half_cnt_r <= 32'h0;
            ref_step   <= 6'h00;
        end else begin
            case (st_r)
                ST_OFF: begin
                    // The ramp and the half limit restart from zero on every enable.
                    edges_r    <= 5'h00;
                    ref_step   <= 6'h00;
                    step_cnt_r <= 32'h0;
                    half_cnt_r <= 32'h0;
                    // Pin high and no hold flags restarts, so thermal and undervoltage self-clear.
                    if (ctrl_s && !long_low && !hold_off) begin
                        st_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (long_low || hold_off) begin
                        st_r <= ST_OFF;
                    end else if (open_trip) begin
                        st_r <= ST_FAULT;
                    end else begin
                        // Edges count only in run; a 32nd edge wraps back to full current.
                        if (fall) begin
                            edges_r <= edges_r + 5'h01;
                        end
                        if (half_cnt_r < HALF_CYC) begin
                            half_cnt_r <= half_cnt_r + 32'h1;
                        end
                        if (ref_step < LEVELS[5:0]) begin
                            if (step_cnt_r == STEP_LAST) begin
                                step_cnt_r <= 32'h0;
                                ref_step   <= ref_step + 6'h01;
                            end else begin
                                step_cnt_r <= step_cnt_r + 32'h1;
                            end
                        end
                    end
                end
                ST_FAULT: begin
                    // Only a shutdown-length low on the pin clears the latch, not the pin merely staying high.
                    if (long_low) begin
                        st_r <= ST_OFF;
                    end
                end
                default: begin
                    st_r <= ST_OFF;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered outputs. Gate and tick share one run condition, so both
    // fall on the clock edge after the one at which a shutdown cause appears.
    wire run_ok = (st_r == ST_RUN) & ~long_low & ~hold_off & ~open_trip;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            sw_gate_en           <= 1'b0;
            sw_clk_tick          <= 1'b0;
            string_current_level <= 5'h00;
            ilim_half            <= 1'b0;
            active               <= 1'b0;
        end else begin
            sw_gate_en           <= run_ok;
            sw_clk_tick          <= sw_tick & run_ok;
            string_current_level <= edges_r;
            ilim_half            <= (st_r == ST_RUN) & (half_cnt_r < HALF_CYC);
            active               <= (st_r == ST_RUN);
        end
    end
endmodule // pcd_ctrl
`default_nettype wire

// [bench/pcd_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker for the dimming control core.
module pcd_props (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       ctrl_pin,
    input wire logic       switch_node_ovp,
    input wire logic       feedback_sense_low,
    input wire logic       uvlo_flag,
    input wire logic       otp_flag,
    input wire logic       sw_gate_en,
    input wire logic       sw_clk_tick,
    input wire logic [4:0] string_current_level,
    input wire logic [5:0] ref_step,
    input wire logic       ilim_half,
    input wire logic       active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_off_no_tick: assert property (!sw_gate_en |-> !sw_clk_tick)
        else $error("tick while switching is off");
    a_tick_gap: assert property (sw_clk_tick |=> !sw_clk_tick [*8])
        else $error("ticks too close");
    a_ref_max: assert property (ref_step <= 6'h20)
        else $error("reference step beyond final");
    a_ref_start: assert property ($rose(active) |-> ref_step <= 6'h01)
        else $error("ramp not restarted");
    a_ref_mono: assert property (active && $past(active) |-> ref_step >= $past(ref_step))
        else $error("ramp went down");
    a_half_begin: assert property ($rose(active) |-> ilim_half)
        else $error("half limit missing at start");
    a_half_end: assert property ($rose(active) |-> ##[1:120] !ilim_half)
        else $error("half limit held too long");
    a_half_run: assert property (ilim_half |-> active)
        else $error("half limit outside run");
    a_uvlo_off: assert property (uvlo_flag [*5] |-> !sw_gate_en)
        else $error("switching under undervoltage");
    a_otp_off: assert property (otp_flag [*5] |-> !sw_gate_en)
        else $error("switching under overtemperature");
endmodule // pcd_props
bind pcd_ctrl pcd_props u_props (.core_clk, .rst_n, .ctrl_pin, .switch_node_ovp,
    .feedback_sense_low, .uvlo_flag, .otp_flag, .sw_gate_en, .sw_clk_tick,
    .string_current_level, .ref_step, .ilim_half, .active);
`default_nettype wire

// [bench/pcd_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host on the control pin. Widths are scaled to the short
// shutdown count of the bench, so pulses stay well under it.
module pcd_host (
    input  wire logic core_clk,
    output var  logic ctrl_pin
);
    initial ctrl_pin = 1'b0;
    task automatic hold(input logic lvl, input int cyc);
        ctrl_pin <= lvl;
        repeat (cyc) @(posedge core_clk);
    endtask
    task automatic enable();
        hold(1'b1, 30);
    endtask
    task automatic pulse();
        hold(1'b0, 10);
        hold(1'b1, 10);
    endtask
    task automatic shut();
        hold(1'b0, 200);
    endtask
endmodule // pcd_host
`default_nettype wire

// [bench/pcd_ctrl_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pcd_regs.vh"
// ==========================================================
// Self-checking bench; long counts are shortened by parameter.
module pcd_ctrl_bench;
    logic       core_clk, rst_n, ovp, fbl, uv, ot;
    wire        ctrl_pin, gate, tick, half, act;
    wire  [4:0] lvl;
    wire  [5:0] step;
    int         error_cnt = 0;
    int         compares = 0;
    pcd_host host (.core_clk(core_clk), .ctrl_pin(ctrl_pin));
    pcd_ctrl #(.SHDN_CYC(50), .STEP_CYC(20), .HALF_CYC(100)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .ctrl_pin(ctrl_pin), .switch_node_ovp(ovp),
        .feedback_sense_low(fbl), .uvlo_flag(uv), .otp_flag(ot), .sw_gate_en(gate),
        .sw_clk_tick(tick), .string_current_level(lvl), .ref_step(step), .ilim_half(half),
        .active(act));
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic wait_act(input logic want, input int lim);
        int n;
        n = 0;
        while (act !== want && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk("active", {5'h0, want}, {5'h0, act});
        if (act !== want) conclude();
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        @(posedge core_clk);
        while (tick !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        if (tick !== 1'b1) begin
            chk("tick_seen", 32'h1, 32'h0);
            conclude();
        end
    endtask
    task automatic t_tick();
        int n;
        wait_tick(n);
        wait_tick(n);
        chk("tick_period", `PCD_SW_DIV, n + 1);
    endtask
    task automatic t_start();
        host.enable();
        wait_act(1'b1, 20);
        chk("gate", 6'h01, {5'h0, gate});
        chk("half", 6'h01, {5'h0, half});
        repeat (120) @(posedge core_clk);
        chk("half_end", 6'h00, {5'h0, half});
        repeat (700) @(posedge core_clk);
        chk("ref_step", 6'h20, step);
    endtask
    task automatic t_dim();
        for (int n = 1; n <= 32; n++) begin
            host.pulse();
            chk("level", 6'(n % 32), {1'b0, lvl});
        end
    endtask
    task automatic t_shut();
        host.shut();
        chk("active_off", 6'h00, {5'h0, act});
        chk("gate_off", 6'h00, {5'h0, gate});
        chk("level_off", 6'h00, {1'b0, lvl});
    endtask
    task automatic t_open();
        host.enable();
        wait_act(1'b1, 20);
        ovp <= 1'b1;
        fbl <= 1'b1;
        repeat (1000) @(posedge core_clk);
        chk("gate_early", 6'h01, {5'h0, gate});
        repeat (500) @(posedge core_clk);
        chk("gate_fault", 6'h00, {5'h0, gate});
        ovp <= 1'b0;
        fbl <= 1'b0;
        repeat (300) @(posedge core_clk);
        chk("gate_held", 6'h00, {5'h0, gate});
        host.shut();
        host.enable();
        wait_act(1'b1, 20);
    endtask
    task automatic t_flags();
        uv <= 1'b1;
        wait_act(1'b0, 20);
        uv <= 1'b0;
        wait_act(1'b1, 20);
        ot <= 1'b1;
        wait_act(1'b0, 20);
        ot <= 1'b0;
        wait_act(1'b1, 20);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        rst_n = 1'b0;
        ovp = 1'b0;
        fbl = 1'b0;
        uv = 1'b0;
        ot = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        t_start();
        t_tick();
        t_dim();
        t_shut();
        t_open();
        t_flags();
        conclude();
    end
endmodule // pcd_ctrl_bench
`default_nettype wire
